// >>> hw/ptpreg_top.sv
// module: ahb-lite register bank for ptp buffer control and shaper slopes
// Summary of operation
// - eight transmit regions, each request and pending
// - bits 18:16 show last sent region
// - bits 15:8 show pending requests not yet sent
// - pending clears when region frame is sent
// - writing one to 7:0 raises request
// - grant sends frame of requested region
// - tx event cleared by any access to the tx control register
// - bits 11:8 show last received buffer
// - rx flush sets write to read address
// - rx event cleared by any access to the rx control register
// - sendSlope twenty bits, reset 2048
// - idleSlope twenty bits, reset 6144
// - arbiter limits av bandwidth by slopes
// - reserved bits read as zero
// - sixteen rx buffers, pointer advances per frame
// - region byte zero length, frame from eighth
// - rx timestamp goes to buffer top
// - tx timestamp goes to region top
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module ptpreg_top
  import ptpreg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // transmit arbiter and frame engine
  output ptpreg_pkg::ptpreg_tx_req_t tx_req,
  input wire logic [7:0] tx_grant,
  input wire ptpreg_pkg::ptpreg_tx_done_t tx_done,
  output logic [2:0] tx_send_region,
  output logic tx_send_valid,
  output logic [7:0] tx_stamp_addr,
  // receive frame engine
  input wire ptpreg_pkg::ptpreg_rx_done_t rx_done,
  input wire logic rx_read_done,
  output logic [3:0] rx_wr_ptr,
  output logic [3:0] rx_rd_ptr,
  output logic [7:0] rx_stamp_addr,
  // shaper slopes
  output logic [19:0] send_slope,
  output logic [19:0] idle_slope,
  // event interrupts
  output logic ptp_tx_irq,
  output logic ptp_rx_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // address phase capture
  ptpreg_sel_t sel_reg;
  ptpreg_sel_t sel_next;
  logic wr_reg;
  logic acc_reg;
  logic addr_ok;

  // flag and value registers
  logic [7:0] pend_reg;
  logic [2:0] tx_last_reg;
  logic [3:0] rx_last_reg;
  logic [19:0] send_slope_reg;
  logic [19:0] idle_slope_reg;
  logic tx_irq_reg;
  logic rx_irq_reg;
  logic [2:0] send_region_reg;
  logic send_valid_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // strobes in data phase
  logic data_wr;
  logic tx_acc;
  logic rx_acc;
  logic [7:0] req_set;
  logic rx_flush;

  assign addr_ok = hsel && hready &&
    (htrans == PTPREG_HTRANS_NONSEQ || htrans == PTPREG_HTRANS_SEQ);

  // address decode
  always_comb begin
    sel_next = PTPREG_SEL_NONE;
    if (haddr == PTPREG_TX_CTRL_OFS) begin
      sel_next = PTPREG_SEL_TX;
    end else if (haddr == PTPREG_RX_CTRL_OFS) begin
      sel_next = PTPREG_SEL_RX;
    end else if (haddr == PTPREG_SEND_SLOPE_OFS) begin
      sel_next = PTPREG_SEL_SEND;
    end else if (haddr == PTPREG_IDLE_SLOPE_OFS) begin
      sel_next = PTPREG_SEL_IDLE;
    end else begin
      sel_next = PTPREG_SEL_NONE;
    end
  end

  // address phase register; unmapped addresses read zero, writes dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= PTPREG_SEL_NONE;
      wr_reg <= 1'b0;
      acc_reg <= 1'b0;
    end else if (hready) begin
      sel_reg <= addr_ok ? sel_next : PTPREG_SEL_NONE;
      wr_reg <= addr_ok && hwrite;
      acc_reg <= addr_ok;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign data_wr = acc_reg && wr_reg;
  assign tx_acc = acc_reg && (sel_reg == PTPREG_SEL_TX);
  assign rx_acc = acc_reg && (sel_reg == PTPREG_SEL_RX);
  assign req_set = (data_wr && sel_reg == PTPREG_SEL_TX) ? hwdata[7:0] : 8'h00;
  assign rx_flush = data_wr && (sel_reg == PTPREG_SEL_RX) &&
    hwdata[PTPREG_RX_FLUSH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // per-region pending flags; a new request wins over the completion clear
  genvar gi;
  generate
    for (gi = 0; gi < PTPREG_TX_REGIONS; gi++) begin : g_region
      logic clr;
      assign clr = tx_done.done && (tx_done.region == 3'(gi));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pend_reg[gi] <= PTPREG_PEND_RST[gi];
        end else if (req_set[gi]) begin
          pend_reg[gi] <= 1'b1;
        end else if (clr) begin
          pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // request to the arbiter, start address of frame body
  assign tx_req.pending = pend_reg;
  assign tx_req.start_addr = PTPREG_TX_FRAME_START;

  // launch the frame of the granted region; lowest granted pending wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_region_reg <= 3'h0;
      send_valid_reg <= 1'b0;
    end else begin
      send_valid_reg <= 1'b0;
      for (int i = PTPREG_TX_REGIONS - 1; i >= 0; i--) begin
        if (tx_grant[i] && pend_reg[i]) begin
          send_region_reg <= 3'(i);
          send_valid_reg <= 1'b1;
        end
      end
    end
  end

  assign tx_send_region = send_region_reg;
  assign tx_send_valid = send_valid_reg;
  // timestamps land in the top word of the region or buffer just used
  assign tx_stamp_addr = PTPREG_STAMP_BYTE;
  assign rx_stamp_addr = PTPREG_STAMP_BYTE;

  // last transmitted region
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_last_reg <= PTPREG_TX_LAST_RST;
    end else if (tx_done.done) begin
      tx_last_reg <= tx_done.region;
    end
  end

  // last received buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_last_reg <= PTPREG_RX_LAST_RST;
    end else if (rx_done.done) begin
      rx_last_reg <= rx_done.buffer;
    end
  end

  // event flags: a completion in the same cycle as the access keeps the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_irq_reg <= 1'b0;
    end else if (tx_done.done) begin
      tx_irq_reg <= 1'b1;
    end else if (tx_acc) begin
      tx_irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_irq_reg <= 1'b0;
    end else if (rx_done.done) begin
      rx_irq_reg <= 1'b1;
    end else if (rx_acc) begin
      rx_irq_reg <= 1'b0;
    end
  end

  assign ptp_tx_irq = tx_irq_reg;
  assign ptp_rx_irq = rx_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shaper slopes; the arbiter applies them as the av bandwidth cap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_slope_reg <= PTPREG_SEND_SLOPE_RST;
    end else if (data_wr && sel_reg == PTPREG_SEL_SEND) begin
      send_slope_reg <= hwdata[19:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_slope_reg <= PTPREG_IDLE_SLOPE_RST;
    end else if (data_wr && sel_reg == PTPREG_SEL_IDLE) begin
      idle_slope_reg <= hwdata[19:0];
    end
  end

  assign send_slope = send_slope_reg;
  assign idle_slope = idle_slope_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receive pointers
  ptpreg_rx_ptr u_rx_ptr (
    .hclk(hclk),
    .hresetn(hresetn),
    .flush(rx_flush),
    .frame_done(rx_done.done),
    .read_done(rx_read_done),
    .wr_ptr(rx_wr_ptr),
    .rd_ptr(rx_rd_ptr)
  );

  // read mux, picked at the address phase so data is registered
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (sel_next)
      PTPREG_SEL_TX: begin
        rdata_next[PTPREG_TX_LAST_LSB +: 3] = tx_last_reg;
        rdata_next[PTPREG_TX_PEND_LSB +: 8] = pend_reg;
      end
      PTPREG_SEL_RX: begin
        rdata_next[PTPREG_RX_LAST_LSB +: 4] = rx_last_reg;
      end
      PTPREG_SEL_SEND: begin
        rdata_next[19:0] = send_slope_reg;
      end
      PTPREG_SEL_IDLE: begin
        rdata_next[19:0] = idle_slope_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // a slope written back to back with its read returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence req_write_s;
    data_wr && sel_reg == PTPREG_SEL_TX && hwdata[0];
  endsequence
  pend_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_write_s |=> pend_reg[0])
    else $error("request did not set pending");
  pend_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_done.done && !req_set[tx_done.region]) |=> !pend_reg[$past(tx_done.region)])
    else $error("pending not cleared after send");
  tx_last_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_done.done |=> tx_last_reg == $past(tx_done.region))
    else $error("last tx region wrong");
  rx_last_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done.done |=> rx_last_reg == $past(rx_done.buffer))
    else $error("last rx buffer wrong");
  tx_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_done.done |=> ptp_tx_irq)
    else $error("tx event not raised");
  tx_irq_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_acc && !tx_done.done) |=> !ptp_tx_irq)
    else $error("tx event not cleared by access");
  rx_irq_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_acc && !rx_done.done) |=> !ptp_rx_irq)
    else $error("rx event not cleared by access");
  grant_send_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_grant[3] && pend_reg[3] && tx_grant[2:0] == 3'h0 && pend_reg[2:0] == 3'h0)
      |=> tx_send_valid && tx_send_region == 3'h3)
    else $error("granted region not sent");
  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:20] == 12'h000)
    else $error("reserved bits not zero");
  slope_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(data_wr && sel_reg == PTPREG_SEL_SEND) |=> $stable(send_slope_reg))
    else $error("send slope changed without write");
endmodule : ptpreg_top

// >>> hw/ptpreg_pkg.sv
// package: register map, field layout, reset values and carriers for ptp buffer control regs
package ptpreg_pkg;
  // register byte addresses
  localparam logic [31:0] PTPREG_TX_CTRL_OFS = 32'h0001_2000;
  localparam logic [31:0] PTPREG_RX_CTRL_OFS = 32'h0001_2004;
  localparam logic [31:0] PTPREG_SEND_SLOPE_OFS = 32'h0001_200c;
  localparam logic [31:0] PTPREG_IDLE_SLOPE_OFS = 32'h0001_2010;
  // sizes
  localparam int PTPREG_TX_REGIONS = 8;
  localparam int PTPREG_RX_BUFFERS = 16;
  localparam int PTPREG_REGION_BYTES = 256;
  localparam logic [7:0] PTPREG_TX_FRAME_START = 8'h07;
  localparam logic [7:0] PTPREG_STAMP_BYTE = 8'hfc;
  // field positions
  localparam int PTPREG_TX_LAST_LSB = 16;
  localparam int PTPREG_TX_PEND_LSB = 8;
  localparam int PTPREG_RX_LAST_LSB = 8;
  localparam int PTPREG_RX_FLUSH_BIT = 0;
  // reset values
  localparam logic [19:0] PTPREG_SEND_SLOPE_RST = 20'h00800;
  localparam logic [19:0] PTPREG_IDLE_SLOPE_RST = 20'h01800;
  localparam logic [2:0] PTPREG_TX_LAST_RST = 3'h0;
  localparam logic [3:0] PTPREG_RX_LAST_RST = 4'h0;
  localparam logic [7:0] PTPREG_PEND_RST = 8'h00;

  // ahb-lite transfer types
  localparam logic [1:0] PTPREG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PTPREG_HTRANS_SEQ = 2'h3;

  // transmit request carrier toward the arbiter
  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] start_addr;
  } ptpreg_tx_req_t;

  // transmit completion from the frame engine
  typedef struct packed {
    logic done;
    logic [2:0] region;
  } ptpreg_tx_done_t;

  // receive completion from the frame engine
  typedef struct packed {
    logic done;
    logic [3:0] buffer;
  } ptpreg_rx_done_t;

  // decoded register select
  typedef enum logic [2:0] {
    PTPREG_SEL_NONE = 3'b000,
    PTPREG_SEL_TX = 3'b001,
    PTPREG_SEL_RX = 3'b010,
    PTPREG_SEL_SEND = 3'b011,
    PTPREG_SEL_IDLE = 3'b100
  } ptpreg_sel_t;
endpackage : ptpreg_pkg

// >>> hw/ptpreg_rx_ptr.sv
// module: receive buffer pointer pair with flush and frame advance
`timescale 1ns/1ps
module ptpreg_rx_ptr
  import ptpreg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic flush,
  input wire logic frame_done,
  input wire logic read_done,
  // pointers
  output logic [3:0] wr_ptr,
  output logic [3:0] rd_ptr
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] wr_reg;
  logic [3:0] rd_reg;

  // write pointer: flush snaps it onto the read pointer, frame moves it on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 4'h0;
    end else if (flush) begin
      wr_reg <= rd_reg;
    end else if (frame_done) begin
      wr_reg <= wr_reg + 4'h1;
    end
  end

  // read pointer follows software consumption from the engine side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 4'h0;
    end else if (read_done && !flush) begin
      rd_reg <= rd_reg + 4'h1;
    end
  end

  assign wr_ptr = wr_reg;
  assign rd_ptr = rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  flush_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flush |=> (wr_reg == $past(rd_reg)))
    else $error("flush did not align write pointer");
  advance_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_done && !flush) |=> (wr_reg == $past(wr_reg) + 4'h1))
    else $error("write pointer did not advance");
endmodule : ptpreg_rx_ptr

// >>> bench/ptpreg_arb_model.sv
// partner model: transmit arbiter and frame engine behind the request lines
`timescale 1ns/1ps
module ptpreg_arb_model
  import ptpreg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // requests and sends from the register bank
  input wire ptpreg_pkg::ptpreg_tx_req_t tx_req,
  input wire logic tx_send_valid,
  input wire logic [2:0] tx_send_region,
  // bench knob: frame time in cycles
  input wire logic [3:0] delay,
  // answers
  output logic [7:0] tx_grant,
  output ptpreg_pkg::ptpreg_tx_done_t tx_done
);
  logic [2:0] st_reg;
  logic [3:0] cnt_reg;
  logic [2:0] region_reg;

  // grant is a single pulse so a held level cannot launch one frame twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= 3'h0;
      cnt_reg <= 4'h0;
      region_reg <= 3'h0;
      tx_grant <= 8'h00;
      tx_done <= '0;
    end else begin
      tx_grant <= 8'h00;
      tx_done <= '0;
      case (st_reg)
        3'h0: if (|tx_req.pending) begin
          tx_grant <= tx_req.pending;
          st_reg <= 3'h1;
        end
        3'h1: st_reg <= 3'h2;
        3'h2: if (tx_send_valid) begin
          region_reg <= tx_send_region;
          cnt_reg <= delay;
          st_reg <= 3'h3;
        end
        3'h3: if (cnt_reg == 4'h0) begin
          tx_done <= {1'b1, region_reg};
          st_reg <= 3'h4;
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
        end
        // gap lets the cleared pending flag land before the next look
        default: st_reg <= 3'h0;
      endcase
    end
  end
endmodule : ptpreg_arb_model

// >>> bench/test_ptpreg_top.sv
// testbench: register bank driven over ahb-lite against the arbiter model
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module test_ptpreg_top;
  import ptpreg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, tx_send_valid, rx_read_done = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [7:0] tx_grant, tx_stamp_addr, rx_stamp_addr;
  logic [2:0] tx_send_region;
  logic [3:0] rx_wr_ptr, rx_rd_ptr, arb_delay = 4'h2;
  logic [19:0] send_slope, idle_slope;
  logic ptp_tx_irq, ptp_rx_irq;
  ptpreg_tx_req_t tx_req;
  ptpreg_tx_done_t tx_done;
  ptpreg_rx_done_t rx_done = '0;
  logic [2:0] sent_q[$];
  int num_errors = 0;
  int cmp_count = 0;

  ptpreg_top ptpreg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_req(tx_req),
    .tx_grant(tx_grant), .tx_done(tx_done), .tx_send_region(tx_send_region),
    .tx_send_valid(tx_send_valid), .tx_stamp_addr(tx_stamp_addr), .rx_done(rx_done),
    .rx_read_done(rx_read_done), .rx_wr_ptr(rx_wr_ptr), .rx_rd_ptr(rx_rd_ptr),
    .rx_stamp_addr(rx_stamp_addr), .send_slope(send_slope), .idle_slope(idle_slope),
    .ptp_tx_irq(ptp_tx_irq), .ptp_rx_irq(ptp_rx_irq));
  ptpreg_arb_model ptpreg_arb_model_i (.hclk(hclk), .hresetn(hresetn), .tx_req(tx_req),
    .tx_send_valid(tx_send_valid), .tx_send_region(tx_send_region), .delay(arb_delay),
    .tx_grant(tx_grant), .tx_done(tx_done));

  always #12.5 hclk = ~hclk;
  // log every frame launch in order
  always @(posedge hclk) if (tx_send_valid === 1'b1) sent_q.push_back(tx_send_region);

  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // one ahb-lite single transfer; address held until hready seen high
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PTPREG_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask : rd

  // watchdog: the full run needs well under this span
  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] r, d;
    logic [7:0] m;
    logic [3:0] b, rp;
    logic [2:0] last;
    logic [2:0] s;
    void'($urandom(62500));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values of all four registers
    rd(PTPREG_TX_CTRL_OFS, r); `CHK(r, 32'h0)
    rd(PTPREG_RX_CTRL_OFS, r); `CHK(r, 32'h0)
    rd(PTPREG_SEND_SLOPE_OFS, r); `CHK(r, {12'h0, PTPREG_SEND_SLOPE_RST})
    rd(PTPREG_IDLE_SLOPE_OFS, r); `CHK(r, {12'h0, PTPREG_IDLE_SLOPE_RST})
    // slopes: random words, upper bits must read as zero
    for (int k = 0; k < 4; k++) begin
      d = $urandom();
      wr(PTPREG_SEND_SLOPE_OFS, d);
      wr(PTPREG_IDLE_SLOPE_OFS, ~d);
      wr(32'h0001_2008, d);
      rd(PTPREG_SEND_SLOPE_OFS, r); `CHK(r, {12'h0, d[19:0]})
      rd(PTPREG_IDLE_SLOPE_OFS, r); `CHK(r, {12'h0, ~d[19:0]})
      `CHK(idle_slope, ~d[19:0])
      rd(32'h0001_2008, r); `CHK(r, 32'h0)
    end
    // transmit requests: all regions, the top one, region three, then random masks
    for (int k = 0; k < 7; k++) begin
      m = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : (k == 2) ? 8'h08 : 8'($urandom_range(255, 1));
      arb_delay <= 4'($urandom_range(7, 0));
      sent_q.delete();
      // regions are taken as already loaded by software
      wr(PTPREG_TX_CTRL_OFS, {8'hff, 16'h0, m});
      rd(PTPREG_TX_CTRL_OFS, r); `CHK(r[15:0], {m, 8'h00})
      `CHK(r[31:19], 13'h0)
      for (int n = 0; n < 200 && r[15:8] != 8'h00; n++) rd(PTPREG_TX_CTRL_OFS, r);
      `CHK(r[15:8], 8'h00)
      for (int i = 0; i < 8; i++) if (m[i]) begin
        s = sent_q.pop_front();
        `CHK(s, 3'(i))
        last = 3'(i);
      end
      `CHK(r[18:16], last)
      `CHK(sent_q.size(), 0)
    end
    // a zero write must not drop a pending request; long frame keeps it pending
    arb_delay <= 4'hf;
    wr(PTPREG_TX_CTRL_OFS, 32'h1);
    wr(PTPREG_TX_CTRL_OFS, 32'h0);
    rd(PTPREG_TX_CTRL_OFS, r); `CHK(r[15:8], 8'h01)
    // transmit event: survives other access, cleared by own register
    for (int n = 0; n < 100 && tx_done.done !== 1'b1; n++) @(posedge hclk);
    @(posedge hclk);
    `CHK(ptp_tx_irq, 1'b1)
    rd(PTPREG_RX_CTRL_OFS, r);
    `CHK(ptp_tx_irq, 1'b1)
    rd(PTPREG_TX_CTRL_OFS, r);
    @(posedge hclk);
    `CHK(ptp_tx_irq, 1'b0)
    // receive frames, wrapping the sixteen buffers
    for (int k = 0; k < 18; k++) begin
      b = rx_wr_ptr;
      rx_done <= {1'b1, b};
      // read pointer ends five to eight ahead, never on the write pointer
      rx_read_done <= (k < 8) && (k < 5 || $urandom_range(1, 0) == 1);
      @(posedge hclk);
      rx_done <= '0;
      rx_read_done <= 1'b0;
      @(posedge hclk);
      `CHK(ptp_rx_irq, 1'b1)
      `CHK(rx_wr_ptr, b + 4'h1)
      rd(PTPREG_RX_CTRL_OFS, r); `CHK(r, {20'h0, b, 8'h00})
      @(posedge hclk);
      `CHK(ptp_rx_irq, 1'b0)
    end
    // flush: zero in bit 0 does nothing, one moves write to read
    b = rx_wr_ptr;
    rp = rx_rd_ptr;
    wr(PTPREG_RX_CTRL_OFS, 32'hffff_fffe);
    @(posedge hclk);
    `CHK(rx_wr_ptr, b)
    wr(PTPREG_RX_CTRL_OFS, 32'h1);
    @(posedge hclk);
    `CHK(rx_wr_ptr, rp)
    rd(PTPREG_RX_CTRL_OFS, r); `CHK(r[7:0], 8'h00)
    `CHK(tx_req.start_addr, PTPREG_TX_FRAME_START)
    `CHK(tx_stamp_addr, PTPREG_STAMP_BYTE)
    `CHK(rx_stamp_addr, PTPREG_STAMP_BYTE)
    `CHK(hresp, 1'b0)
    // second reset in mid-run restores the slopes
    wr(PTPREG_SEND_SLOPE_OFS, 32'h5);
    hresetn <= 1'b0;
    @(posedge hclk);
    `CHK(send_slope, PTPREG_SEND_SLOPE_RST)
    `CHK(idle_slope, PTPREG_IDLE_SLOPE_RST)
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(PTPREG_SEND_SLOPE_OFS, r); `CHK(r, {12'h0, PTPREG_SEND_SLOPE_RST})
    end_of_test();
  end
endmodule : test_ptpreg_top
